// file: tdfc_defines.svh
// constants for the two-degree-of-freedom command filter block
`ifndef TDFC_DEFINES_SVH
`define TDFC_DEFINES_SVH
`define TDFC_EN_BIT          0
`define TDFC_SYNC_BIT        3
`define TDFC_DEVSEL_BIT      14
`define TDFC_ACCSEL_BIT      3
`define TDFC_SMOOTH_MAX      16'd10000
`define TDFC_SMOOTH_CLAMP    16'd2000
`define TDFC_ADJ_MAX         16'd2000
`define TDFC_DAMP_MAX        7'd99
`define TDFC_VISC_MAX        16'd10000
`define TDFC_CLK_HZ          10000000
`define TDFC_DETECT_US       125
`define TDFC_DETECT_CYC      ((`TDFC_CLK_HZ / 1000000) * `TDFC_DETECT_US)
`define TDFC_APPLY_DLY_CYC   8
// damping ratio codes in Q1.7 (128 = 1.0)
`define TDFC_Z_100           8'd128
`define TDFC_Z_086           8'd110
`define TDFC_Z_071           8'd91
`define TDFC_Z_050           8'd64
`define TDFC_Z_035           8'd45
`endif

// file: tdfc_pkg.sv
// types for the two-degree-of-freedom command filter block
package tdfc_pkg;
  typedef enum logic [1:0] {TDFC_IDLE, TDFC_DELAY, TDFC_READY} tdfc_apply_e;
  typedef struct packed {
    logic        second_order;
    logic [7:0]  zeta;
  } tdfc_damp_s;
endpackage

// file: tdfc_cfg_if.sv
// interface carrying the applied damping code to the decoder and the decoded settings back
`timescale 1ns/1ps
interface tdfc_cfg_if;
  logic [6:0] damp_code;
  logic [8:0] cmd_damp;
  logic [8:0] adj_damp;
  modport src (output damp_code, input cmd_damp, input adj_damp);
  modport dec (input damp_code, output cmd_damp, output adj_damp);
endinterface

// file: tdfc_damp_dec.sv
// decoder of the two-digit damping selection
`timescale 1ns/1ps
`include "tdfc_defines.svh"
module tdfc_damp_dec
  import tdfc_pkg::*;
(
  tdfc_cfg_if.dec cfg
);
  function automatic tdfc_damp_s digit_to_damp(input logic [3:0] d);
    tdfc_damp_s r;
    r.second_order = (d >= 4'h5);
    unique case (d)
      4'h5:    r.zeta = `TDFC_Z_100;
      4'h6:    r.zeta = `TDFC_Z_086;
      4'h7:    r.zeta = `TDFC_Z_071;
      4'h8:    r.zeta = `TDFC_Z_050;
      4'h9:    r.zeta = `TDFC_Z_035;
      default: r.zeta = 8'h00;
    endcase
    return r;
  endfunction

  logic [6:0] tens;
  logic [6:0] units;
  always_comb
  begin
    tens  = cfg.damp_code / 7'd10;
    units = cfg.damp_code - 7'((tens * 7'd10));
    cfg.cmd_damp = digit_to_damp(units[3:0]);
    cfg.adj_damp = digit_to_damp(tens[3:0]);
  end
endmodule

// file: tdfc_filter_top.sv
// command shaping for two-degree-of-freedom full-closed control
`timescale 1ns/1ps
`include "tdfc_defines.svh"
// Behaviour
// - tuning-type bit selects standard or synchronization, only while mode enabled.
// - smoothing constant accepted to 10000, applied value clamped to 2000.
// - adjust filter time constant programmable 0 to 2000 in 0.1 ms.
// - damping units digit for command filter, tens digit for adjust filter.
// - digits 0-4 first order; 5-9 second order with listed damping ratios.
// - torque command plus command velocity times viscous friction gain.
// - new settings switch when positioning complete and pulse rises from zero.
// - changes reach calculation after a delay; switch during delay is deferred.
// - deviation output method chosen by deviation-change bit.
// - monitored position command source chosen by accumulation bit.
// - synchronization type in full-closed two-dof mode raises setting error.
module tdfc_filter_top
  import tdfc_pkg::*;
#(
  parameter int DETECT_CYC = `TDFC_DETECT_CYC,
  parameter int DELAY_CYC  = `TDFC_APPLY_DLY_CYC
)(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic        [15:0] function_extension_setup_two,
  input  wire logic        [15:0] command_smoothing_time_constant,
  input  wire logic        [15:0] adjust_filter_time_constant,
  input  wire logic        [6:0]  filter_damping_select,
  input  wire logic        [15:0] viscous_friction_gain,
  input  wire logic        [15:0] comm_extension_setup_two,
  input  wire logic        [15:0] comm_extension_setup_six,
  input  wire logic               full_closed_mode,
  input  wire logic               positioning_complete,
  input  wire logic signed [15:0] cmd_pulse_in,
  input  wire logic signed [15:0] cmd_velocity,
  input  wire logic signed [15:0] torque_cmd_in,
  input  wire logic signed [31:0] dev_standard,
  input  wire logic signed [31:0] dev_encoder,
  input  wire logic signed [31:0] pos_cmd_filtered,
  input  wire logic signed [31:0] pos_cmd_accum,
  output logic                    two_dof_active,
  output logic                    sync_tuning_sel,
  output logic                    control_mode_setting_error,
  output logic             [15:0] smooth_tc_applied,
  output logic             [15:0] adjust_tc_applied,
  output logic                    cmd_second_order,
  output logic             [7:0]  cmd_zeta,
  output logic                    adj_second_order,
  output logic             [7:0]  adj_zeta,
  output logic                    settings_switched,
  output logic signed      [15:0] torque_cmd_out,
  output logic signed      [31:0] monitor_deviation,
  output logic signed      [31:0] monitor_pos_cmd
);
  tdfc_cfg_if cfg ();

  logic               en_ff;
  logic               rst_d_ff;
  logic [15:0]        stg_smooth_ff;
  logic [15:0]        stg_adjust_ff;
  logic [6:0]         stg_damp_ff;
  logic [15:0]        pend_smooth_ff;
  logic [15:0]        pend_adjust_ff;
  logic [6:0]         pend_damp_ff;
  logic [6:0]         app_damp_ff;
  logic [15:0]        nxt_smooth;
  logic [15:0]        nxt_adjust;
  logic [6:0]         nxt_damp;
  tdfc_apply_e        apply_ff;
  logic [15:0]        dly_cnt_ff;
  logic [15:0]        det_cnt_ff;
  logic               pulse_zero_ff;
  logic               pulse_rise;
  logic               det_tick;
  logic               changed;
  logic               switch_now;
  logic [15:0]        visc_gain;
  logic signed [47:0] visc_prod;
  logic signed [31:0] visc_term;
  logic signed [31:0] tq_sum;

  // one limit test shared by the refused settings and the saturated viscous gain
  function automatic logic over_limit(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim);
  endfunction

  // torque saturates instead of wrapping on a large compensation
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    logic signed [15:0] r;
    if (v > 32'sh00007FFF)
      r = 16'sh7FFF;
    else if (v < -32'sh00008000)
      r = 16'sh8000;
    else
      r = v[15:0];
    return r;
  endfunction

  tdfc_damp_dec u_dec (
    .cfg (cfg)
  );
  assign cfg.damp_code = app_damp_ff;

  // mode enable latched once after reset release: takes effect only on restart
  always_ff @(posedge clk)
  begin
    rst_d_ff <= srst;
    if (srst)
      en_ff <= 1'b0;
    else if (rst_d_ff)
      en_ff <= function_extension_setup_two[`TDFC_EN_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      two_dof_active  <= 1'b0;
      sync_tuning_sel <= 1'b0;
    end
    else
    begin
      two_dof_active  <= en_ff;
      sync_tuning_sel <= en_ff & function_extension_setup_two[`TDFC_SYNC_BIT];
    end
  end

  // sticky until restart, so a short-lived bad setting is still seen
  always_ff @(posedge clk)
  begin
    if (srst)
      control_mode_setting_error <= 1'b0;
    else if (en_ff & full_closed_mode & function_extension_setup_two[`TDFC_SYNC_BIT])
      control_mode_setting_error <= 1'b1;
  end

  // out-of-range writes are refused and the previous value kept
  always_comb
  begin
    nxt_smooth = over_limit(command_smoothing_time_constant, `TDFC_SMOOTH_MAX) ? stg_smooth_ff
               : command_smoothing_time_constant;
    nxt_adjust = over_limit(adjust_filter_time_constant, `TDFC_ADJ_MAX) ? stg_adjust_ff
               : adjust_filter_time_constant;
    nxt_damp   = over_limit(16'(filter_damping_select), 16'(`TDFC_DAMP_MAX)) ? stg_damp_ff
               : filter_damping_select;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stg_smooth_ff <= 16'h0000;
      stg_adjust_ff <= 16'h0000;
      stg_damp_ff   <= 7'h00;
    end
    else
    begin
      stg_smooth_ff <= nxt_smooth;
      stg_adjust_ff <= nxt_adjust;
      stg_damp_ff   <= nxt_damp;
    end
  end

  // pulse sampled only on the detection interval, not every clock
  assign det_tick   = (det_cnt_ff == 16'(DETECT_CYC - 1));
  assign pulse_rise = det_tick & pulse_zero_ff & (cmd_pulse_in != 16'sh0000);
  assign changed    = (stg_smooth_ff != pend_smooth_ff) | (stg_adjust_ff != pend_adjust_ff) |
                      (stg_damp_ff != pend_damp_ff);
  // one condition shared by the state machine and the applied copy
  assign switch_now = (apply_ff == TDFC_READY) & ~changed & positioning_complete & pulse_rise;

  always_ff @(posedge clk)
  begin
    if (srst)
      det_cnt_ff <= 16'h0000;
    else
      det_cnt_ff <= det_tick ? 16'h0000 : det_cnt_ff + 16'h0001;
  end

  // assume an idle zero pulse before the first tick
  always_ff @(posedge clk)
  begin
    if (srst)
      pulse_zero_ff <= 1'b1;
    else if (det_tick)
      pulse_zero_ff <= (cmd_pulse_in == 16'sh0000);
  end

  // a new value restarts the internal delay; switching instants then wait
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      apply_ff       <= TDFC_IDLE;
      dly_cnt_ff     <= 16'h0000;
      pend_smooth_ff <= 16'h0000;
      pend_adjust_ff <= 16'h0000;
      pend_damp_ff   <= 7'h00;
    end
    else
    begin
      if (changed)
      begin
        pend_smooth_ff <= stg_smooth_ff;
        pend_adjust_ff <= stg_adjust_ff;
        pend_damp_ff   <= stg_damp_ff;
        dly_cnt_ff     <= 16'h0000;
        apply_ff       <= TDFC_DELAY;
      end
      else
      begin
        unique case (apply_ff)
          TDFC_IDLE:  apply_ff <= TDFC_IDLE;
          TDFC_DELAY:
          begin
            dly_cnt_ff <= dly_cnt_ff + 16'h0001;
            if (dly_cnt_ff == 16'(DELAY_CYC - 1))
              apply_ff <= TDFC_READY;
          end
          TDFC_READY:
            if (switch_now)
              apply_ff <= TDFC_IDLE;
          // unused code falls back to idle
          default:
            apply_ff <= TDFC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      smooth_tc_applied <= 16'h0000;
      adjust_tc_applied <= 16'h0000;
      app_damp_ff       <= 7'h00;
      settings_switched <= 1'b0;
    end
    else
    begin
      settings_switched <= 1'b0;
      // settings move only on a switching instant, never in mid-motion
      if (switch_now)
      begin
        // clamp only the applied copy; the written value stays as stored
        smooth_tc_applied <= (pend_smooth_ff > `TDFC_SMOOTH_CLAMP) ? `TDFC_SMOOTH_CLAMP
                           : pend_smooth_ff;
        adjust_tc_applied <= pend_adjust_ff;
        app_damp_ff       <= pend_damp_ff;
        settings_switched <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_second_order <= 1'b0;
      cmd_zeta         <= 8'h00;
      adj_second_order <= 1'b0;
      adj_zeta         <= 8'h00;
    end
    else
    begin
      {cmd_second_order, cmd_zeta} <= cfg.cmd_damp;
      {adj_second_order, adj_zeta} <= cfg.adj_damp;
    end
  end

  // gain units 0.1 %/(10000 r/min): torque in 0.1 %, velocity in r/min
  always_comb
  begin
    // out-of-range gain saturates rather than being refused
    visc_gain = over_limit(viscous_friction_gain, `TDFC_VISC_MAX) ? `TDFC_VISC_MAX
              : viscous_friction_gain;
    visc_prod = 48'(cmd_velocity) * 48'($signed({1'b0, visc_gain}));
    visc_term = 32'(visc_prod / 48'sd10000);
    tq_sum    = 32'(torque_cmd_in) + (en_ff ? visc_term : 32'sh00000000);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      torque_cmd_out <= 16'sh0000;
    else
      torque_cmd_out <= sat16(tq_sum);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      monitor_deviation <= 32'sh00000000;
      monitor_pos_cmd   <= 32'sh00000000;
    end
    else
    begin
      // source selects act at once; no restart needed
      monitor_deviation <= comm_extension_setup_two[`TDFC_DEVSEL_BIT] ? dev_encoder
                         : dev_standard;
      monitor_pos_cmd   <= comm_extension_setup_six[`TDFC_ACCSEL_BIT] ? pos_cmd_accum
                         : pos_cmd_filtered;
    end
  end
endmodule

// file: tdfc_filter_top_properties.sv
// port assertions for the two-dof command filter
`timescale 1ns/1ps
module tdfc_filter_checker (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic        [15:0] comm_extension_setup_two,
  input wire logic        [15:0] comm_extension_setup_six,
  input wire logic signed [31:0] dev_encoder,
  input wire logic signed [31:0] pos_cmd_filtered,
  input wire logic               two_dof_active,
  input wire logic               sync_tuning_sel,
  input wire logic               control_mode_setting_error,
  input wire logic        [15:0] smooth_tc_applied,
  input wire logic               cmd_second_order,
  input wire logic        [7:0]  cmd_zeta,
  input wire logic               settings_switched,
  input wire logic signed [31:0] monitor_deviation,
  input wire logic signed [31:0] monitor_pos_cmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_sync_needs_enable: assert property (sync_tuning_sel |-> two_dof_active)
    else $error("sync tuning without enable");
  a_smooth_clamped: assert property (smooth_tc_applied <= 16'h07D0)
    else $error("smoothing above clamp");
  a_zeta_code_legal: assert property (cmd_second_order == (cmd_zeta inside
    {8'h80, 8'h6E, 8'h5B, 8'h40, 8'h2D})) else $error("bad zeta code");
  // skip the first edge after reset, outputs still zero there
  a_dev_encoder_sel: assert property (!$past(srst) && comm_extension_setup_two[14]
    |=> monitor_deviation == $past(dev_encoder)) else $error("deviation source");
  a_pos_filt_sel: assert property (!$past(srst) && !comm_extension_setup_six[3]
    |=> monitor_pos_cmd == $past(pos_cmd_filtered)) else $error("position source");
  a_applied_hold: assert property ($changed(smooth_tc_applied) |-> settings_switched)
    else $error("applied value moved without switch");
  a_switch_one_cycle: assert property (settings_switched |=> !settings_switched)
    else $error("switch pulse too long");
  a_error_sticky: assert property (control_mode_setting_error |=> control_mode_setting_error)
    else $error("setting error dropped");
  c_switch: cover property (settings_switched);
  c_error: cover property (control_mode_setting_error);
  c_second: cover property (cmd_second_order);
endmodule
bind tdfc_filter_top tdfc_filter_checker i_chk (.clk(clk), .srst(srst),
  .comm_extension_setup_two(comm_extension_setup_two),
  .comm_extension_setup_six(comm_extension_setup_six), .dev_encoder(dev_encoder),
  .pos_cmd_filtered(pos_cmd_filtered), .two_dof_active(two_dof_active),
  .sync_tuning_sel(sync_tuning_sel), .smooth_tc_applied(smooth_tc_applied),
  .control_mode_setting_error(control_mode_setting_error),
  .cmd_second_order(cmd_second_order), .cmd_zeta(cmd_zeta),
  .settings_switched(settings_switched), .monitor_deviation(monitor_deviation),
  .monitor_pos_cmd(monitor_pos_cmd));

// file: tdfc_cmd_source.sv
// motion command source driving pulse and positioning complete
`timescale 1ns/1ps
module tdfc_cmd_source #(
  parameter int D = 10
)(
  input  wire logic          clk,
  output logic signed [15:0] cmd_pulse_in,
  output logic               positioning_complete
);
  initial
  begin
    cmd_pulse_in = 16'sh0000;
    positioning_complete = 1'b0;
  end
  // two ticks of zero then two nonzero, so some tick sees the rise
  task automatic rise(input logic pc);
    positioning_complete = pc;
    cmd_pulse_in = 16'sh0000;
    repeat (2 * D) @(negedge clk);
    cmd_pulse_in = 16'($urandom_range(1, 32767));
    repeat (2 * D) @(negedge clk);
    cmd_pulse_in = 16'sh0000;
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the two-dof command filter
`timescale 1ns/1ps
`include "tdfc_defines.svh"
module testbench;
  import tdfc_pkg::*;
  localparam int D = 10;
  typedef struct packed {logic [15:0] s; logic [15:0] a; logic [6:0] d;} tdfc_exp_s;
  logic               clk = 1'b0, srst = 1'b1, fc = 1'b1, pcmp, act, sync, err, sw, c2, a2;
  logic        [15:0] fes = 16'h0000, sm = 16'h0000, adj = 16'h0000, gain = 16'h0000;
  logic        [15:0] ces2 = 16'h0000, ces6 = 16'h0000, sm_o, adj_o;
  logic        [6:0]  damp = 7'h00;
  logic        [7:0]  cz, az;
  logic signed [15:0] vel = 16'sh0000, tq = 16'sh0000, pulse, tq_o;
  logic signed [31:0] dvs = 32'sh0, dve = 32'sh0, pf = 32'sh0, pa = 32'sh0, mdev, mpos;
  tdfc_exp_s          q[$];
  tdfc_exp_s          e;
  int                 failures = 0;
  int                 cmp_count = 0;
  int                 x;
  always #50 clk = ~clk;
  tdfc_filter_top #(.DETECT_CYC(D), .DELAY_CYC(4)) i_tdfc_filter_top (
    .clk(clk), .srst(srst), .function_extension_setup_two(fes),
    .command_smoothing_time_constant(sm), .adjust_filter_time_constant(adj),
    .filter_damping_select(damp), .viscous_friction_gain(gain),
    .comm_extension_setup_two(ces2), .comm_extension_setup_six(ces6),
    .full_closed_mode(fc), .positioning_complete(pcmp), .cmd_pulse_in(pulse),
    .cmd_velocity(vel), .torque_cmd_in(tq), .dev_standard(dvs), .dev_encoder(dve),
    .pos_cmd_filtered(pf), .pos_cmd_accum(pa), .two_dof_active(act),
    .sync_tuning_sel(sync), .control_mode_setting_error(err), .smooth_tc_applied(sm_o),
    .adjust_tc_applied(adj_o), .cmd_second_order(c2), .cmd_zeta(cz),
    .adj_second_order(a2), .adj_zeta(az), .settings_switched(sw),
    .torque_cmd_out(tq_o), .monitor_deviation(mdev), .monitor_pos_cmd(mpos));
  tdfc_cmd_source #(.D(D)) i_tdfc_cmd_source (.clk(clk), .cmd_pulse_in(pulse),
    .positioning_complete(pcmp));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  function automatic logic [8:0] zt(input int d);
    logic [7:0] z[5] = '{`TDFC_Z_100, `TDFC_Z_086, `TDFC_Z_071, `TDFC_Z_050, `TDFC_Z_035};
    return d < 5 ? 9'h000 : {1'b1, z[d-5]};
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // enable is only sampled after reset, so each mode needs its own restart
  task automatic do_reset(input logic [15:0] f);
    fes = f;
    srst = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic apply(input logic [15:0] s, input logic [15:0] a, input logic [6:0] d);
    sm = s;
    adj = a;
    damp = d;
    q.push_back({s, a, d});
    i_tdfc_cmd_source.rise(1'b1);
    repeat (3 * D) @(negedge clk);
    chk(q.size() == 0, "no switch seen");
  endtask
  always @(negedge clk)
  begin
    ces2 <= 16'($urandom);
    ces6 <= 16'($urandom);
    dvs <= 32'($urandom);
    dve <= 32'($urandom);
    pf <= 32'($urandom);
    pa <= 32'($urandom);
  end
  always @(negedge clk)
    if (sw === 1'b1)
    begin
      if (q.size() == 0)
        chk(1'b0, "unexpected switch");
      else
      begin
        e = q.pop_front();
        chk(sm_o === (e.s > 16'h07D0 ? 16'h07D0 : e.s), "smoothing");
        chk(adj_o === e.a, "adjust");
        @(negedge clk);
        chk({c2, cz} === zt(e.d % 10), "cmd damping");
        chk({a2, az} === zt(e.d / 10), "adj damping");
      end
    end
  initial
  begin
    void'($urandom(32'h0425));
    do_reset(16'h0008);
    chk(act === 1'b0 && sync === 1'b0 && err === 1'b0, "disabled mode");
    do_reset(16'h0009);
    chk(act === 1'b1 && sync === 1'b1 && err === 1'b1, "sync in full-closed");
    fes = 16'h0000;
    repeat (4) @(negedge clk);
    chk(act === 1'b1, "enable must wait for restart");
    fc = 1'b0;
    do_reset(16'h0009);
    chk(sync === 1'b1 && err === 1'b0, "sync outside full-closed");
    fc = 1'b1;
    do_reset(16'h0001);
    chk(act === 1'b1 && err === 1'b0, "standard type");
    $display("test mode select done");
    for (int i = 0; i < 4; i++)
    begin
      gain = i[0] ? 16'h2710 : 16'h1388;
      vel = 16'(2 * $urandom_range(0, 8000) - 8000);
      tq = 16'($urandom_range(0, 16000) - 8000);
      x = int'(tq) + int'(vel) * int'(gain) / 10000;
      @(negedge clk);
      chk(tq_o === 16'(x), "viscous compensation");
      chk(mdev === (ces2[`TDFC_DEVSEL_BIT] ? dve : dvs), "deviation monitor");
      chk(mpos === (ces6[`TDFC_ACCSEL_BIT] ? pa : pf), "position monitor");
    end
    gain = 16'h0000;
    $display("test viscous done");
    sm = 16'h0005;
    i_tdfc_cmd_source.rise(1'b0);
    for (int u = 0; u < 10; u++)
      apply(16'($urandom_range(0, 10000)), 16'($urandom_range(0, 2000)), 7'(u + 10 * (9 - u)));
    apply(16'h2710, 16'h07D0, 7'h63);
    $display("test filter switching done");
    wrap_up();
  end
  // whole run needs about 850 cycles
  initial
  begin
    #1000000;
    failures++;
    wrap_up();
  end
endmodule
